// ===== rtl/lmo_pkg.sv
/*
 * Shared constants: indices, reset values, ranges,
 * timing and the excitation state type.
 * Assumes one 100 MHz clock domain.
 */
package lmo_pkg;

    // Data widths
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int IDX_W  = 16;
    localparam int SUB_W  = 8;

    // Indices
    localparam logic [IDX_W-1:0] IDX_POST_DIST = 16'h24a0;
    localparam logic [IDX_W-1:0] IDX_POST_VEL  = 16'h24a1;
    localparam logic [IDX_W-1:0] IDX_SEG_DIST  = 16'h2500;
    localparam logic [IDX_W-1:0] IDX_SEG_VEL   = 16'h2510;
    localparam logic [IDX_W-1:0] IDX_SEG_TYPE  = 16'h2520;
    localparam logic [IDX_W-1:0] IDX_SEG_CHAIN = 16'h2530;
    localparam logic [IDX_W-1:0] IDX_TIMER     = 16'h2900;
    localparam logic [IDX_W-1:0] IDX_CMD       = 16'h2e00;
    localparam logic [IDX_W-1:0] IDX_RSP       = 16'h2e10;

    // Sub-indices
    localparam logic [SUB_W-1:0] SUB_COUNT = 8'h00;
    localparam logic [SUB_W-1:0] SUB_FIRST = 8'h01;
    localparam logic [SUB_W-1:0] SUB_ID    = 8'h02;
    localparam logic [SUB_W-1:0] SUB_DATA  = 8'h03;

    // Entry counts
    localparam int               SEG_COUNT  = 4;
    localparam logic [SUB_W-1:0] MBOX_COUNT = 8'h03;

    // Reset values
    localparam logic [WORD_W-1:0] RST_DIST      = 32'h0000_0000;
    localparam logic [WORD_W-1:0] RST_VEL       = 32'h0000_03e8;
    localparam logic              RST_MOVE_TYPE = 1'b1;
    localparam logic              RST_CHAIN     = 1'b0;
    localparam logic [WORD_W-1:0] RST_TIMER     = 32'h0000_0000;

    // Ranges
    localparam logic [WORD_W-1:0] VEL_MIN   = 32'h0000_0001;
    localparam logic [WORD_W-1:0] FLAG_MAX  = 32'h0000_0001;
    localparam logic [WORD_W-1:0] TIMER_MAX = 32'h1dcd_6500;

    // Timing: timer counts milliseconds
    localparam int CLK_FREQ_HZ    = 100_000_000;
    localparam int TIMER_UNIT_MS  = 1;
    localparam int MS_CYCLES_DFLT = CLK_FREQ_HZ / 1000 * TIMER_UNIT_MS;

    // Excitation state, one-hot
    typedef enum logic [1:0] {
        LMO_EXC_OFF = 2'b01,
        LMO_EXC_ON  = 2'b10
    } lmo_exc_e;

endpackage

// ===== rtl/lmo_edge_sync.sv
/*
 * Two-stage synchroniser with edge detection.
 * Assumes an input of any timing.
 */
`timescale 1ns/10ps
module lmo_edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Raw input
    input  wire logic din,
    // Level and edges
    output logic      level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } lmo_sync_s;

    lmo_sync_s st_r;
    lmo_sync_s st_nxt;

    // Shift chain
    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = din;
        st_nxt.sync = st_r.meta;
        st_nxt.prev = st_r.sync;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Edges
    assign level = st_r.sync;
    assign rise  = st_r.sync & ~st_r.prev; // R15
    assign fall  = ~st_r.sync & st_r.prev; // R15

endmodule // lmo_edge_sync

// ===== rtl/lmo_ms_timer.sv
/*
 * Millisecond timer: tick divider and loadable
 * saturating up-counter.
 * Assumes loads are range checked.
 */
`timescale 1ns/10ps
module lmo_ms_timer #(
    parameter int MS_CYCLES = lmo_pkg::MS_CYCLES_DFLT
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    // Load
    input  wire logic                       load,
    input  wire logic [lmo_pkg::WORD_W-1:0] load_value,
    // Count
    output logic      [lmo_pkg::WORD_W-1:0] count
);
    import lmo_pkg::*;

    localparam int              DIV_W   = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
    localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(MS_CYCLES - 1);

    typedef struct packed {
        logic [DIV_W-1:0]  div;
        logic [WORD_W-1:0] count;
    } lmo_timer_s;

    lmo_timer_s st_r;
    lmo_timer_s st_nxt;
    logic       tick;

    // Tick and saturating count; load restarts divider
    always_comb begin
        st_nxt = st_r;
        tick   = (st_r.div == DIV_TOP);
        if (load) begin
            st_nxt.div   = '0;
            st_nxt.count = load_value; // R7
        end else begin
            st_nxt.div = tick ? '0 : st_r.div + DIV_W'(1);
            if (tick && (st_r.count < TIMER_MAX)) begin
                st_nxt.count = st_r.count + WORD_W'(1); // R7
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{div: '0, count: RST_TIMER};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count = st_r.count;

endmodule // lmo_ms_timer

// ===== rtl/lmo_objects.sv
/*
 * Linked motion objects and excitation control.
 * Post-sensor values, segment table, timer and
 * mailboxes by index and sub-index; excitation
 * from the enable input and a software command.
 * Assumes one clock,
 * one access per cycle
 * and external limits.
 */
// Notes on behaviour
// R1 - Post-sensor distance: 32-bit RW, 0 to position limit, reset 0.
// R2 - Post-sensor velocity: 32-bit RW, 1 to velocity limit, reset 1000.
// R3 - Four signed segment distances, reset 0; read-only count 4.
// R4 - Four segment velocities, 1 to velocity limit, reset 1000.
// R5 - Per-segment move type: 0 absolute, 1 incremental, reset 1.
// R6 - Three chain flags for segments 0-2: 1 chains onward, 0 ends; reset 0.
// R7 - Millisecond running timer, RW, 0 to 500,000,000.
// R8 - When on and off requests collide, turning current off wins.
// R9 - Falling enable edge while excited clears excitation and status.
// R10 - Enable low: excitation command writes ignored.
// R11 - Rising enable edge sets excitation and status.
// R12 - With enable high, command 0 de-energises, command 1 energises.
// R13 - Already unexcited: a low level or falling edge changes nothing.
// R14 - Command mailbox takes word, identifier, data; response is read-only.
// R15 - Enable edges: synchronised level against previous value.
`timescale 1ns/10ps
module lmo_objects #(
    parameter int SEG_N     = lmo_pkg::SEG_COUNT,
    parameter int MS_CYCLES = lmo_pkg::MS_CYCLES_DFLT
) (
    // Clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   rst_b,
    // Object dictionary access
    input  wire logic                                   od_wr,
    input  wire logic                                   od_rd,
    input  wire logic [lmo_pkg::IDX_W-1:0]              od_index,
    input  wire logic [lmo_pkg::SUB_W-1:0]              od_subindex,
    input  wire logic [lmo_pkg::WORD_W-1:0]             od_wdata,
    output logic      [lmo_pkg::WORD_W-1:0]             od_rdata,
    output logic                                        od_ack,
    output logic                                        od_abort,
    // Limits
    input  wire logic [lmo_pkg::WORD_W-1:0]             position_limit,
    input  wire logic [lmo_pkg::WORD_W-1:0]             velocity_limit,
    // Excitation
    input  wire logic                                   current_enable_input,
    input  wire logic                                   excitation_cmd_wr,
    input  wire logic                                   excitation_cmd_value,
    output logic                                        excitation_status_output,
    output logic                                        motor_energize,
    // Command mailbox
    output logic      [lmo_pkg::HALF_W-1:0]             mailbox_input_word,
    output logic      [lmo_pkg::HALF_W-1:0]             mailbox_command_identifier,
    output logic      [lmo_pkg::WORD_W-1:0]             mailbox_write_value,
    output logic                                        mailbox_command_strobe,
    // Response mailbox
    input  wire logic                                   reply_load,
    input  wire logic [lmo_pkg::HALF_W-1:0]             reply_output_word_in,
    input  wire logic [lmo_pkg::HALF_W-1:0]             reply_identifier_in,
    input  wire logic [lmo_pkg::WORD_W-1:0]             reply_value_in,
    // Motion parameters
    output logic      [lmo_pkg::WORD_W-1:0]             post_sensor_distance,
    output logic      [lmo_pkg::WORD_W-1:0]             post_sensor_velocity,
    output logic      [SEG_N-1:0][lmo_pkg::WORD_W-1:0]  segment_target_value,
    output logic      [SEG_N-1:0][lmo_pkg::WORD_W-1:0]  segment_running_speed,
    output logic      [SEG_N-1:0]                       segment_move_type,
    output logic      [SEG_N-2:0]                       segment_chain_flag,
    output logic      [lmo_pkg::WORD_W-1:0]             elapsed_time_ms
);
    import lmo_pkg::*;

    localparam int               CHAIN_N   = SEG_N - 1;
    localparam int               SEL_W     = (SEG_N > 1) ? $clog2(SEG_N) : 1;
    localparam logic [SUB_W-1:0] SEG_N_B   = SUB_W'(SEG_N);
    localparam logic [SUB_W-1:0] CHAIN_N_B = SUB_W'(CHAIN_N);

    typedef struct packed {
        logic [WORD_W-1:0]             post_dist;
        logic [WORD_W-1:0]             post_vel;
        logic [SEG_N-1:0][WORD_W-1:0]  seg_dist;
        logic [SEG_N-1:0][WORD_W-1:0]  seg_vel;
        logic [SEG_N-1:0]              seg_type;
        logic [CHAIN_N-1:0]            seg_chain;
        logic [HALF_W-1:0]             mb_in;
        logic [HALF_W-1:0]             mb_id;
        logic [WORD_W-1:0]             mb_val;
        logic                          mb_strobe;
        logic [HALF_W-1:0]             rp_out;
        logic [HALF_W-1:0]             rp_id;
        logic [WORD_W-1:0]             rp_val;
        lmo_exc_e                      exc;
        logic                          energize;
        logic [WORD_W-1:0]             rdata;
        logic                          ack;
        logic                          abort;
    } lmo_state_s;

    lmo_state_s        st_r;
    lmo_state_s        st_nxt;
    logic [1:0]        rst_sync_r;
    logic              rst_int_b;
    logic              en_level;
    logic              en_rise;
    logic              en_fall;
    logic [WORD_W-1:0] timer_count;
    logic              timer_load;
    logic              hit;
    logic              read_only;
    logic              range_ok;
    logic              wr_go;
    logic [WORD_W-1:0] rval;
    logic [SUB_W-1:0]  sub_m1;
    logic [SEL_W-1:0]  sel;
    logic              in_seg;
    logic              in_chain;
    logic              vel_ok;
    logic              cmd_on;
    logic              cmd_off;
    logic              turn_on;
    logic              turn_off;

    // Reset release, two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_int_b = rst_sync_r[1];

    // Enable synchroniser
    lmo_edge_sync u_enable_sync (
        .clk   (clk),
        .rst_b (rst_int_b),
        .din   (current_enable_input),
        .level (en_level),
        .rise  (en_rise),
        .fall  (en_fall)
    );

    // Running timer
    lmo_ms_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_run_timer (
        .clk        (clk),
        .rst_b      (rst_int_b),
        .load       (timer_load),
        .load_value (od_wdata),
        .count      (timer_count)
    );

    // Segment select
    assign sub_m1   = od_subindex - SUB_FIRST;
    assign sel      = sub_m1[SEL_W-1:0];
    assign in_seg   = (od_subindex >= SUB_FIRST) && (od_subindex <= SEG_N_B);
    assign in_chain = (od_subindex >= SUB_FIRST) && (od_subindex <= CHAIN_N_B);
    assign vel_ok   = (od_wdata >= VEL_MIN) && (od_wdata <= velocity_limit);

    // Entry decode
    always_comb begin
        hit       = 1'b0;
        read_only = 1'b0;
        range_ok  = 1'b1;
        rval      = '0;
        case (od_index)
            IDX_POST_DIST: begin
                hit      = (od_subindex == SUB_COUNT);
                range_ok = (od_wdata <= position_limit); // R1
                rval     = st_r.post_dist;
            end
            IDX_POST_VEL: begin
                hit      = (od_subindex == SUB_COUNT);
                range_ok = vel_ok; // R2
                rval     = st_r.post_vel;
            end
            IDX_SEG_DIST: begin
                if (od_subindex == SUB_COUNT) begin
                    hit       = 1'b1;
                    read_only = 1'b1;
                    rval      = WORD_W'(SEG_N_B); // R3
                end else begin
                    hit      = in_seg;
                    range_ok = ($signed(od_wdata) <= $signed(position_limit))
                             && ($signed(od_wdata) >= -$signed(position_limit)); // R3
                    rval     = st_r.seg_dist[sel];
                end
            end
            IDX_SEG_VEL: begin
                if (od_subindex == SUB_COUNT) begin
                    hit       = 1'b1;
                    read_only = 1'b1;
                    rval      = WORD_W'(SEG_N_B);
                end else begin
                    hit      = in_seg;
                    range_ok = vel_ok; // R4
                    rval     = st_r.seg_vel[sel];
                end
            end
            IDX_SEG_TYPE: begin
                if (od_subindex == SUB_COUNT) begin
                    hit       = 1'b1;
                    read_only = 1'b1;
                    rval      = WORD_W'(SEG_N_B);
                end else begin
                    hit      = in_seg;
                    range_ok = (od_wdata <= FLAG_MAX); // R5
                    rval     = WORD_W'(st_r.seg_type[sel]);
                end
            end
            IDX_SEG_CHAIN: begin
                if (od_subindex == SUB_COUNT) begin
                    hit       = 1'b1;
                    read_only = 1'b1;
                    rval      = WORD_W'(CHAIN_N_B); // R6
                end else begin
                    hit      = in_chain;
                    range_ok = (od_wdata <= FLAG_MAX); // R6
                    rval     = WORD_W'(st_r.seg_chain[sel]);
                end
            end
            IDX_TIMER: begin
                hit      = (od_subindex == SUB_COUNT);
                range_ok = (od_wdata <= TIMER_MAX); // R7
                rval     = timer_count;
            end
            IDX_CMD, IDX_RSP: begin
                hit       = (od_subindex <= MBOX_COUNT);
                read_only = (od_index == IDX_RSP) || (od_subindex == SUB_COUNT); // R14
                range_ok  = (od_subindex == SUB_DATA) || (od_wdata[WORD_W-1:HALF_W] == '0);
                case (od_subindex)
                    SUB_COUNT: rval = WORD_W'(MBOX_COUNT);
                    SUB_FIRST: rval = (od_index == IDX_CMD) ? WORD_W'(st_r.mb_in)
                                                            : WORD_W'(st_r.rp_out);
                    SUB_ID:    rval = (od_index == IDX_CMD) ? WORD_W'(st_r.mb_id)
                                                            : WORD_W'(st_r.rp_id);
                    default:   rval = (od_index == IDX_CMD) ? st_r.mb_val : st_r.rp_val;
                endcase
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    assign wr_go      = od_wr && hit && !read_only && range_ok;
    assign timer_load = wr_go && (od_index == IDX_TIMER); // R7

    // Excitation requests; software commands gated by enable level
    assign cmd_on   = en_level && excitation_cmd_wr && excitation_cmd_value;  // R10 R12
    assign cmd_off  = en_level && excitation_cmd_wr && !excitation_cmd_value; // R10 R12
    assign turn_on  = en_rise || cmd_on;  // R11
    assign turn_off = en_fall || cmd_off; // R9

    // Next state
    always_comb begin
        st_nxt           = st_r;
        st_nxt.ack       = 1'b0;
        st_nxt.abort     = 1'b0;
        st_nxt.mb_strobe = 1'b0;
        if (od_wr || od_rd) begin
            st_nxt.ack   = od_rd ? hit : wr_go;
            st_nxt.abort = od_rd ? !hit : !wr_go;
            if (od_rd && hit) begin
                st_nxt.rdata = rval;
            end
        end
        if (wr_go) begin
            case (od_index)
                IDX_POST_DIST: st_nxt.post_dist      = od_wdata; // R1
                IDX_POST_VEL:  st_nxt.post_vel       = od_wdata; // R2
                IDX_SEG_DIST:  st_nxt.seg_dist[sel]  = od_wdata; // R3
                IDX_SEG_VEL:   st_nxt.seg_vel[sel]   = od_wdata; // R4
                IDX_SEG_TYPE:  st_nxt.seg_type[sel]  = od_wdata[0]; // R5
                IDX_SEG_CHAIN: st_nxt.seg_chain[sel] = od_wdata[0]; // R6
                IDX_CMD: begin
                    case (od_subindex)
                        SUB_FIRST: st_nxt.mb_in = od_wdata[HALF_W-1:0]; // R14
                        SUB_ID:    st_nxt.mb_id = od_wdata[HALF_W-1:0]; // R14
                        default: begin
                            st_nxt.mb_val    = od_wdata; // R14
                            st_nxt.mb_strobe = 1'b1;
                        end
                    endcase
                end
                default: begin
                    st_nxt.mb_strobe = 1'b0;
                end
            endcase
        end
        // Response loaded by interpreter only
        if (reply_load) begin
            st_nxt.rp_out = reply_output_word_in; // R14
            st_nxt.rp_id  = reply_identifier_in;  // R14
            st_nxt.rp_val = reply_value_in;       // R14
        end
        // Off beats on
        unique case (st_r.exc)
            LMO_EXC_OFF: begin
                if (turn_on && !turn_off) begin // R8 R11 R12 R13
                    st_nxt.exc = LMO_EXC_ON;
                end
            end
            LMO_EXC_ON: begin
                if (turn_off) begin // R8 R9 R12
                    st_nxt.exc = LMO_EXC_OFF;
                end
            end
            default: begin
                st_nxt.exc = LMO_EXC_OFF;
            end
        endcase
        st_nxt.energize = (st_nxt.exc == LMO_EXC_ON); // R9 R11
    end

    // State register
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            st_r           <= '0;
            st_r.post_dist <= RST_DIST;          // R1
            st_r.post_vel  <= RST_VEL;           // R2
            st_r.seg_dist  <= {SEG_N{RST_DIST}}; // R3
            st_r.seg_vel   <= {SEG_N{RST_VEL}};  // R4
            st_r.seg_type  <= {SEG_N{RST_MOVE_TYPE}}; // R5
            st_r.seg_chain <= {CHAIN_N{RST_CHAIN}};   // R6
            st_r.exc       <= LMO_EXC_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs from the state register and the timer count
    assign od_rdata                   = st_r.rdata;
    assign od_ack                     = st_r.ack;
    assign od_abort                   = st_r.abort;
    assign excitation_status_output   = st_r.energize;
    assign motor_energize             = st_r.energize;
    assign mailbox_input_word         = st_r.mb_in;
    assign mailbox_command_identifier = st_r.mb_id;
    assign mailbox_write_value        = st_r.mb_val;
    assign mailbox_command_strobe     = st_r.mb_strobe;
    assign post_sensor_distance       = st_r.post_dist;
    assign post_sensor_velocity       = st_r.post_vel;
    assign segment_target_value       = st_r.seg_dist;
    assign segment_running_speed      = st_r.seg_vel;
    assign segment_move_type          = st_r.seg_type;
    assign segment_chain_flag         = st_r.seg_chain;
    assign elapsed_time_ms            = timer_count;

endmodule // lmo_objects

// ===== tb/lmo_master.sv
/* Object access master model. Assumes calls start after a clk edge. */
`timescale 1ns/10ps
module lmo_master (
    // Clock and answer
    input  wire logic        clk, od_ack, od_abort,
    input  wire logic [31:0] od_rdata,
    // Request
    output logic             od_wr = 1'b0, od_rd = 1'b0,
    output logic      [15:0] od_index = 16'h0,
    output logic      [7:0]  od_subindex = 8'h0,
    output logic      [31:0] od_wdata = 32'h0
);
    // One-cycle request; released fields invert
    task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
                        input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
        @(posedge clk);
        #1 {od_wr, od_rd, od_index, od_subindex, od_wdata} = {w, !w, i, s, d};
        @(posedge clk);
        #1 {q, r} = {od_rdata, od_ack, od_abort};
        {od_wr, od_rd, od_index, od_subindex, od_wdata} = {2'b00, ~{i, s, d}};
    endtask
endmodule // lmo_master

// ===== tb/lmo_objects_properties.sv
/* Checker for lmo_objects ports. Assumes binding. */
`timescale 1ns/10ps
module lmo_objects_chk
    import lmo_pkg::*;
(
    // Clock, reset and access
    input wire logic        clk, rst_b, od_wr, od_rd, od_ack, od_abort,
    input wire logic [15:0] od_index,
    input wire logic [7:0]  od_subindex,
    // Excitation, mailbox and timer
    input wire logic        current_enable_input, excitation_cmd_wr, excitation_cmd_value,
    input wire logic        excitation_status_output, mailbox_command_strobe,
    input wire logic [31:0] elapsed_time_ms
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Access answers and mailbox strobe
    a_access_answered: assert property ((od_wr || od_rd) |=> od_ack != od_abort)
        else $error("access not answered");
    a_no_stray_answer: assert property (!(od_wr || od_rd) |=> !(od_ack || od_abort))
        else $error("answer without access");
    a_strobe_cause: assert property (mailbox_command_strobe ==
        $past(od_wr && od_index == IDX_CMD && od_subindex == SUB_DATA))
        else $error("strobe without data write");
    // Excitation decisions and timer cap
    a_rise_excites: assert property ($rose(current_enable_input) ##1
        (current_enable_input && !excitation_cmd_wr) [*2] |=> excitation_status_output)
        else $error("rise did not excite");
    a_fall_clears: assert property ($fell(current_enable_input) ##1
        (!current_enable_input) [*2] |=> !excitation_status_output)
        else $error("fall did not clear");
    a_off_wins: assert property (excitation_cmd_wr && !excitation_cmd_value |=>
        !excitation_status_output) else $error("off command lost");
    a_on_command: assert property (current_enable_input [*4] ##0
        (excitation_cmd_wr && excitation_cmd_value) |=> excitation_status_output)
        else $error("on command lost");
    a_low_ignores: assert property ((!current_enable_input) [*4] ##0 excitation_cmd_wr
        |=> !excitation_status_output) else $error("command taken while disabled");
    a_timer_cap: assert property (elapsed_time_ms <= TIMER_MAX)
        else $error("timer above top");
    // Main scenarios
    c_strobe: cover property (mailbox_command_strobe);
    c_abort: cover property (od_abort);
    c_excited: cover property ($rose(excitation_status_output));
endmodule // lmo_objects_chk
bind lmo_objects lmo_objects_chk chk (.clk, .rst_b, .od_wr, .od_rd, .od_ack, .od_abort,
    .od_index, .od_subindex, .current_enable_input, .excitation_cmd_wr, .excitation_cmd_value,
    .excitation_status_output, .mailbox_command_strobe, .elapsed_time_ms);

// ===== tb/testbench.sv
/* Bench for lmo_objects. Assumes lmo_master. */
`timescale 1ns/10ps
module testbench;
    import lmo_pkg::*;
    logic             clk = 1'b0, rst_b = 1'b0, od_wr, od_rd, od_ack, od_abort, stat, mot, stb;
    logic             cen = 1'b0, cwr = 1'b0, cval = 1'b0, rld = 1'b0;
    logic [15:0]      od_index, mb_in, mb_id, rpo, rpi;
    logic [7:0]       od_subindex;
    logic [31:0]      od_wdata, od_rdata, pd, pv, tmr, mb_v, q, rpv;
    logic [3:0][31:0] st, sv;
    logic [6:0]       flg;
    logic [1:0]       r;
    int               errors = 0, comparisons = 0;
    // Clock
    always #5 clk = ~clk;
    lmo_master m (.clk, .od_ack, .od_abort, .od_rdata, .od_wr, .od_rd, .od_index,
        .od_subindex, .od_wdata);
    lmo_objects #(.SEG_N(4), .MS_CYCLES(4)) uut (.clk, .rst_b, .od_wr, .od_rd, .od_index,
        .od_subindex, .od_wdata, .od_rdata, .od_ack, .od_abort,
        .position_limit(32'h1000), .velocity_limit(32'h2000), .current_enable_input(cen),
        .excitation_cmd_wr(cwr), .excitation_cmd_value(cval), .excitation_status_output(stat),
        .motor_energize(mot), .mailbox_input_word(mb_in), .mailbox_command_identifier(mb_id),
        .mailbox_write_value(mb_v), .mailbox_command_strobe(stb), .reply_load(rld),
        .reply_output_word_in(rpo), .reply_identifier_in(rpi),
        .reply_value_in(rpv), .post_sensor_distance(pd), .post_sensor_velocity(pv),
        .segment_target_value(st), .segment_running_speed(sv),
        .segment_move_type(flg[6:3]), .segment_chain_flag(flg[2:0]), .elapsed_time_ms(tmr));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Access; d is write or expected read value
    task acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                       input logic [31:0] d, input logic ab);
        m.xfer(w, i, s, d, q, r);
        check(r, {!ab, ab});
        if (!w && !ab) check(q, d);
    endtask
    task cmd(input logic v, input logic e);
        @(posedge clk);
        #1 {cwr, cval} = {1'b1, v};
        @(posedge clk);
        #1 cwr = 1'b0;
        check({stat, mot}, {e, e});
    endtask
    task t_objects();
        acc(0, IDX_POST_DIST, 0, 32'h0, 0);
        acc(1, IDX_POST_DIST, 0, 32'h1001, 1);
        acc(1, IDX_POST_DIST, 0, 32'h1000, 0);
        check(pd, 32'h1000);
        acc(0, IDX_POST_VEL, 0, 32'h3e8, 0);
        acc(1, IDX_POST_VEL, 0, 32'h0, 1);
        acc(1, IDX_POST_VEL, 0, 32'h2000, 0);
        check(pv, 32'h2000);
        for (int k = 1; k < 5; k++) begin
            acc(0, IDX_SEG_DIST, k[7:0], 32'h0, 0);
            acc(0, IDX_SEG_VEL, k[7:0], 32'h3e8, 0);
            acc(0, IDX_SEG_TYPE, k[7:0], 32'h1, 0);
            acc(0, IDX_SEG_CHAIN, k[7:0], 32'h0, k == 4);
        end
        acc(0, IDX_SEG_DIST, 0, 32'h4, 0);
        acc(1, IDX_SEG_DIST, 0, 32'h4, 1);
        acc(0, IDX_SEG_CHAIN, 0, 32'h3, 0);
        acc(1, IDX_SEG_DIST, 1, 32'hffff_f000, 0);
        acc(1, IDX_SEG_VEL, 4, 32'h0, 1);
        acc(1, IDX_SEG_VEL, 4, 32'h2000, 0);
        acc(1, IDX_SEG_TYPE, 1, 32'h0, 0);
        acc(1, IDX_SEG_CHAIN, 3, 32'h1, 0);
        check(st[0], 32'hffff_f000);
        check(sv[3], 32'h2000);
        check(flg, 7'h74);
        acc(1, IDX_TIMER, 0, 32'h1dcd_6501, 1);
        acc(1, IDX_TIMER, 0, 32'h1dcd_64ff, 0);
        check(tmr, 32'h1dcd_64ff);
        repeat (12) @(posedge clk);
        #1 check(tmr, TIMER_MAX);
        $display("test objects done");
    endtask
    task t_mbox();
        acc(1, IDX_CMD, 1, 32'h1234, 0);
        acc(1, IDX_CMD, 2, 32'h0042, 0);
        acc(1, IDX_CMD, 3, 32'hdead_beef, 0);
        check(stb, 1'b1);
        check({mb_in, mb_id}, 32'h1234_0042);
        check(mb_v, 32'hdead_beef);
        acc(1, IDX_RSP, 1, 32'h0, 1);
        {rpo, rpi, rpv, rld} = {16'h5a5a, 16'h0033, 32'hcafe_0001, 1'b1};
        @(posedge clk);
        #1 rld = 1'b0;
        acc(0, IDX_RSP, 1, 32'h5a5a, 0);
        acc(0, IDX_RSP, 2, 32'h0033, 0);
        acc(0, IDX_RSP, 3, 32'hcafe_0001, 0);
        acc(0, 16'h2600, 0, 32'h0, 1);
        $display("test mailbox done");
    endtask
    task t_excite();
        cen = 1'b1;
        @(posedge clk);
        cmd(0, 0);
        cmd(1, 1);
        cmd(0, 0);
        cmd(1, 1);
        cen = 1'b0;
        repeat (2) @(posedge clk);
        #1 check(stat, 1'b1);
        @(posedge clk);
        #1 check({stat, mot}, 2'b00);
        cmd(1, 0);
        repeat (4) @(posedge clk);
        #1 check(stat, 1'b0);
        cen = 1'b1;
        repeat (3) @(posedge clk);
        #1 check({stat, mot}, 2'b11);
        $display("test excitation done");
    endtask
    task stop_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        errors++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #1 t_objects();
        t_mbox();
        t_excite();
        stop_test();
    end
endmodule // testbench
